/* File: hw/hrb_pkg.sv */
package hrb_pkg;

    // ------------------------------------------------------------
    // Buffer geometry
    // ------------------------------------------------------------
    localparam int HRB_WORDS  = 16;
    localparam int HRB_IDX_W  = 4;
    localparam int HRB_CNT_W  = 5;
    localparam int HRB_FIFO_D = 8;

    // ------------------------------------------------------------
    // Host address map (host_address_bits)
    // ------------------------------------------------------------
    localparam logic [3:0] HRB_A_RES_LO  = 4'h0;
    localparam logic [3:0] HRB_A_RES_HI  = 4'h1;
    localparam logic [3:0] HRB_A_RX_LO   = 4'h2;
    localparam logic [3:0] HRB_A_RX_HI   = 4'h3;
    localparam logic [3:0] HRB_A_HW_STAT = 4'h4;
    localparam logic [3:0] HRB_A_HW_CTRL = 4'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int HRB_CW_OWN     = 7;
    localparam int HRB_CW_CNT_MSB = 4;
    localparam logic [15:0] HRB_CW_MASK = 16'h009f;
    localparam int HRB_HS_OWN  = 0;
    localparam int HRB_HS_DMA  = 1;
    localparam int HRB_HS_PEND = 2;
    localparam int HRB_HS_IRQ  = 3;
    localparam int HRB_HC_RXIE = 0;
    localparam int HRB_HC_STIE = 1;
    localparam int HRB_HC_DMAE = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_IDLE  = 2'b00,
        ACC_READ  = 2'b01,
        ACC_WRITE = 2'b10
    } hrb_acc_e;

    typedef struct packed {
        logic [HRB_IDX_W-1:0] addr;
        logic [15:0]          data;
    } hrb_wr_s;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       ack_n;
        logic [3:0] addr;
        logic [7:0] data;
    } hrb_pins_s;

    localparam hrb_pins_s HRB_PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                            ack_n: 1'b1, addr: 4'h0, data: 8'h00};

endpackage

/* File: hw/hrb_sync.sv */
`timescale 1ns/1ps
module hrb_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Data
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* File: hw/hrb_fifo.sv */
`timescale 1ns/1ps
module hrb_fifo #(
    parameter int W     = 20,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output      logic         in_ready,
    // Drain side
    output      logic         out_valid,
    input  wire logic         out_ready,
    output      logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic          push;
    logic          pop;

    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign out_data = mem[rd_ptr_q];
    assign count_d  = count_q + CW'(push) - CW'(pop);

    function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Flags registered so neither side sees a combinational path
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_q  <= '0;
            rd_ptr_q  <= '0;
            count_q   <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= nxt(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= nxt(rd_ptr_q);
            end
            count_q   <= count_d;
            in_ready  <= (count_d != CW'(DEPTH));
            out_valid <= (count_d != '0);
        end
    end
endmodule

/* File: hw/hrb_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Sixteen-bit result word; host can only read it, host writes do nothing.
// - Firmware result write sets status pending; interrupt asserts if enabled.
// - Host read of result upper byte clears pending and releases interrupt.
// - Receive buffer holds sixteen 16-bit words, thirty-two bytes.
// - Host reads buffer sequentially through one port; address made internally.
// - Only one of host and device owns the buffer; device decides changes.
// - Control word: ownership bit 7, word count bits 4-0, other bits zero.
// - Ownership 0: device writes any location. Ownership 1: host reads port.
// - Ownership resets to zero, shows in status, drives DMA request.
// - Five-bit address counter cleared when device writes ownership 1.
// - Counter advances on upper-byte port access only.
// - Port is 8 bits; processor access picks byte by lowest address bit.
// - DMA access selected by acknowledge; host address bits ignored.
// - DMA byte toggle flips per DMA access while host owns, cleared on ownership 0 to 1.
// - While host owns, counter equal to word count returns ownership.
// - Firmware fills buffer, then sets count and ownership, then refills.
// - DMA request follows ownership; drops when last word returns buffer.
// - Interrupt asserted while ownership set and its enable set.
// - DMA request and its status stay low unless DMA enable set.
module hrb_top #(
    parameter int FIFO_DEPTH = hrb_pkg::HRB_FIFO_D
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Firmware result word
    input  wire logic             fw_result_we,
    input  wire logic [15:0]      fw_result_wdata,
    output      logic             fw_status_pending,
    // Firmware buffer control
    input  wire logic             fw_ctrl_we,
    input  wire logic [15:0]      fw_ctrl_wdata,
    output      logic [15:0]      fw_ctrl_word,
    output      logic             fw_buf_drained,
    // Firmware buffer writes
    input  wire logic             fw_wr_valid,
    input  wire hrb_pkg::hrb_wr_s fw_wr,
    output      logic             fw_wr_ready,
    // Host bus pins
    input  wire logic             host_cs_n,
    input  wire logic             host_rd_n,
    input  wire logic             host_wr_n,
    input  wire logic             rx_dma_ack_n,
    input  wire logic [3:0]       host_address_bits,
    input  wire logic [7:0]       host_data_in,
    output      logic [7:0]       host_data_out,
    output      logic             host_data_oe_n,
    // Host signalling
    output      logic             host_interrupt_n,
    output      logic             rx_dma_request
);
    import hrb_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    hrb_pins_s pins_raw;
    hrb_pins_s pins;

    assign pins_raw = {host_cs_n, host_rd_n, host_wr_n, rx_dma_ack_n,
                       host_address_bits, host_data_in};

    hrb_sync #(
        .W       ($bits(hrb_pins_s)),
        .RST_VAL (HRB_PINS_IDLE)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       (pins_raw),
        .q       (pins)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    hrb_acc_e             st_q;
    hrb_acc_e             st_d;
    logic [15:0]          result_q;
    logic                 owner_q;
    logic [HRB_CNT_W-1:0] frame_q;
    logic [HRB_CNT_W-1:0] cnt_q;
    logic                 tog_q;
    logic                 irq_ie_q;
    logic                 st_ie_q;
    logic                 dma_en_q;
    logic                 acc_dma_q;
    logic                 acc_hi_q;
    logic                 acc_rx_q;
    logic [3:0]           acc_addr_q;
    logic [15:0]          mem [HRB_WORDS];

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic       rd_start;
    logic       wr_start;
    logic       rd_end;
    logic       wr_end;
    logic       start_dma;
    logic       start_hi;
    logic       start_rx;
    logic       rx_hit;
    logic       rx_adv;
    logic       res_hi_rd;
    logic       ctrl_wr;
    logic       fw_ctrl_ok;
    logic       handoff;
    logic       cmp_hit;
    logic       drain_valid;
    logic       drain_ready;
    logic       drain_fire;
    logic       irq_d;
    logic [7:0] hw_stat;
    logic [7:0] rd_byte;
    logic [15:0] rx_word;
    hrb_wr_s    drain_word;

    function automatic logic [7:0] pick(input logic [15:0] w, input logic hi);
        return hi ? w[15:8] : w[7:0];
    endfunction

    assign rd_start  = (st_q == ACC_IDLE) & ~pins.rd_n & (~pins.cs_n | ~pins.ack_n);
    assign wr_start  = (st_q == ACC_IDLE) & ~pins.wr_n & ~pins.cs_n & pins.rd_n;
    assign rd_end    = (st_q == ACC_READ) & pins.rd_n;
    assign wr_end    = (st_q == ACC_WRITE) & pins.wr_n;
    assign start_dma = ~pins.ack_n;
    assign start_hi  = start_dma ? tog_q : pins.addr[0];
    assign start_rx  = start_dma | (pins.addr[3:1] == HRB_A_RX_LO[3:1]);
    assign rx_word   = mem[cnt_q[HRB_IDX_W-1:0]];

    // Stray port accesses while the device owns are harmless
    assign rx_hit    = rd_end & acc_rx_q & owner_q;
    assign rx_adv    = rx_hit & acc_hi_q;
    assign res_hi_rd = rd_end & ~acc_rx_q & (acc_addr_q == HRB_A_RES_HI);
    assign ctrl_wr   = wr_end & (acc_addr_q == HRB_A_HW_CTRL);

    // Handing over with words still queued would expose stale data
    assign fw_ctrl_ok = fw_ctrl_we & (~fw_ctrl_wdata[HRB_CW_OWN] | ~drain_valid);
    assign handoff    = fw_ctrl_ok & fw_ctrl_wdata[HRB_CW_OWN];
    assign cmp_hit    = owner_q & (cnt_q == frame_q);
    assign drain_ready = ~owner_q;
    assign drain_fire  = drain_valid & drain_ready;
    assign irq_d = (fw_status_pending & st_ie_q) | (owner_q & irq_ie_q);

    always_comb begin
        hw_stat              = '0;
        hw_stat[HRB_HS_OWN]  = owner_q;
        hw_stat[HRB_HS_DMA]  = rx_dma_request;
        hw_stat[HRB_HS_PEND] = fw_status_pending;
        hw_stat[HRB_HS_IRQ]  = ~host_interrupt_n;
    end

    assign rd_byte = start_rx                       ? pick(rx_word, start_hi) :
                     (pins.addr == HRB_A_RES_LO)    ? result_q[7:0] :
                     (pins.addr == HRB_A_RES_HI)    ? result_q[15:8] :
                     (pins.addr == HRB_A_HW_STAT)   ? hw_stat : 8'h00;

    assign fw_ctrl_word = {8'h00, owner_q, 2'b00, frame_q};

    // ------------------------------------------------------------
    // Firmware write queue
    // ------------------------------------------------------------
    hrb_fifo #(
        .W         ($bits(hrb_wr_s)),
        .DEPTH     (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (fw_wr_valid),
        .in_data   (fw_wr),
        .in_ready  (fw_wr_ready),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (drain_word)
    );

    always_ff @(posedge clk) begin
        if (drain_fire) begin
            mem[drain_word.addr] <= drain_word.data;
        end
    end

    // ------------------------------------------------------------
    // Host access sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ACC_IDLE: begin
                if (rd_start) begin
                    st_d = ACC_READ;
                end else if (wr_start) begin
                    st_d = ACC_WRITE;
                end
            end
            ACC_READ: begin
                if (pins.rd_n) begin
                    st_d = ACC_IDLE;
                end
            end
            ACC_WRITE: begin
                if (pins.wr_n) begin
                    st_d = ACC_IDLE;
                end
            end
            default: st_d = ACC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q           <= ACC_IDLE;
            host_data_out  <= 8'h00;
            host_data_oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
            if (rd_start) begin
                host_data_out  <= rd_byte;
                host_data_oe_n <= 1'b0;
            end else if (rd_end) begin
                host_data_oe_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_dma_q  <= 1'b0;
            acc_hi_q   <= 1'b0;
            acc_rx_q   <= 1'b0;
            acc_addr_q <= 4'h0;
        end else if (rd_start | wr_start) begin
            acc_dma_q  <= start_dma & rd_start;
            acc_hi_q   <= start_hi;
            acc_rx_q   <= start_rx & rd_start;
            acc_addr_q <= pins.addr;
        end
    end

    // ------------------------------------------------------------
    // Result word and hardware control
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_q <= 16'h0000;
        end else if (fw_result_we) begin
            result_q <= fw_result_wdata;
        end
    end

    // Firmware update wins over a simultaneous host clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fw_status_pending <= 1'b0;
        end else if (fw_result_we) begin
            fw_status_pending <= 1'b1;
        end else if (res_hi_rd) begin
            fw_status_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_ie_q <= 1'b0;
            st_ie_q  <= 1'b0;
            dma_en_q <= 1'b0;
        end else if (ctrl_wr) begin
            irq_ie_q <= pins.data[HRB_HC_RXIE];
            st_ie_q  <= pins.data[HRB_HC_STIE];
            dma_en_q <= pins.data[HRB_HC_DMAE];
        end
    end

    // ------------------------------------------------------------
    // Ownership, counter, toggle
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            owner_q <= 1'b0;
            frame_q <= '0;
        end else if (fw_ctrl_ok) begin
            owner_q <= fw_ctrl_wdata[HRB_CW_OWN];
            frame_q <= fw_ctrl_wdata[HRB_CW_CNT_MSB:0];
        end else if (cmp_hit) begin
            owner_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (handoff) begin
            cnt_q <= '0;
        end else if (rx_adv) begin
            cnt_q <= cnt_q + HRB_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tog_q <= 1'b0;
        end else if (handoff & ~owner_q) begin
            tog_q <= 1'b0;
        end else if (rx_hit & acc_dma_q) begin
            tog_q <= ~tog_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_interrupt_n <= 1'b1;
            rx_dma_request   <= 1'b0;
            fw_buf_drained   <= 1'b1;
        end else begin
            host_interrupt_n <= ~irq_d;
            rx_dma_request   <= owner_q & dma_en_q;
            fw_buf_drained   <= ~drain_valid;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_RESULT_RO: assert property (!fw_result_we |=> $stable(result_q))
        else $error("result word changed without firmware write");
    AST_PEND_SET: assert property (fw_result_we |=> fw_status_pending ##1
        (!host_interrupt_n || !st_ie_q))
        else $error("status pending or interrupt missing after result write");
    AST_PEND_CLR: assert property (res_hi_rd && !fw_result_we |=> !fw_status_pending)
        else $error("upper byte read did not clear pending");
    AST_IRQ_REL: assert property (!fw_status_pending && !(owner_q && irq_ie_q)
        |=> host_interrupt_n)
        else $error("interrupt held with no cause");
    AST_CW_LOAD: assert property (fw_ctrl_ok |=>
        fw_ctrl_word == ($past(fw_ctrl_wdata) & HRB_CW_MASK))
        else $error("control word does not match write");
    AST_EXCL: assert property (owner_q |-> !drain_fire)
        else $error("device wrote buffer while host owns it");
    AST_RST_OWN: assert property (disable iff (1'b0) sys_rst |=> !owner_q)
        else $error("ownership not zero after reset");
    AST_HANDOFF: assert property (handoff |=> cnt_q == '0 && owner_q &&
        ($past(owner_q) || !tog_q))
        else $error("handoff did not clear counter");
    AST_LOW_BYTE: assert property (rx_hit && !acc_hi_q && !handoff |=> $stable(cnt_q))
        else $error("low byte access moved counter");
    AST_TOGGLE: assert property (rx_hit && acc_dma_q && !handoff
        |=> tog_q != $past(tog_q))
        else $error("dma toggle did not flip");
    AST_RETURN: assert property (cmp_hit && !fw_ctrl_ok |=> !owner_q ##1 !rx_dma_request)
        else $error("ownership not returned on count match");
    AST_DREQ: assert property (owner_q && dma_en_q |=> rx_dma_request)
        else $error("dma request missing while host owns");
    AST_DMA_EN: assert property (!dma_en_q |=> !rx_dma_request)
        else $error("dma request without enable");
    AST_IRQ_RX: assert property (owner_q && irq_ie_q |=> !host_interrupt_n)
        else $error("ownership interrupt missing");
    AST_IDLE_PORT: assert property (rd_end && acc_rx_q && !owner_q && !handoff
        |=> $stable(cnt_q) && $stable(tog_q))
        else $error("idle port access changed counter or toggle");

    COV_HANDOFF: cover property (handoff ##[1:200] cmp_hit);
    COV_FIFO_FULL: cover property (!fw_wr_ready && owner_q);
    COV_STATUS_RD: cover property (fw_status_pending ##[1:100] res_hi_rd);
    COV_DMA_RD: cover property (rx_hit && acc_dma_q && acc_hi_q);
endmodule

/* File: bench/hrb_host_model.sv */
`timescale 1ns/1ps
module hrb_host_model (
    // Clock
    input  wire logic       clk,
    // Pins toward the device
    output      logic       cs_n,
    output      logic       rd_n,
    output      logic       wr_n,
    output      logic       ack_n,
    output      logic [3:0] addr,
    output      logic [7:0] din,
    // Device answer
    input  wire logic [7:0] dout,
    input  wire logic       oe_n
);
    initial begin
        cs_n  = 1'b1;
        rd_n  = 1'b1;
        wr_n  = 1'b1;
        ack_n = 1'b1;
        addr  = 4'h0;
        din   = 8'h00;
    end

    // ------------------------------------------------------------
    // One host cycle, processor or DMA
    // ------------------------------------------------------------
    // Strobe low 6 clk, high 5 clk: above the minimum the device needs
    task automatic access(input logic wr, input logic dma, input logic [3:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        cs_n  <= dma;
        ack_n <= !dma;
        addr  <= dma ? ~a : a;
        din   <= d;
        rd_n  <= wr;
        wr_n  <= !wr;
        repeat (5) @(posedge clk);
        @(negedge clk);
        // Undriven bus reads back as the inverse of the last value
        q = oe_n ? ~dout : dout;
        @(posedge clk);
        cs_n  <= 1'b1;
        ack_n <= 1'b1;
        rd_n  <= 1'b1;
        wr_n  <= 1'b1;
        // Write data outlives the strobe: device samples it after synchronising
        @(posedge clk);
        addr  <= ~addr;
        din   <= ~din;
        repeat (3) @(posedge clk);
        // End off the edge so callers see settled outputs
        @(negedge clk);
    endtask
endmodule

/* File: bench/hrb_top_tb.sv */
`timescale 1ns/1ps
module hrb_top_tb;
    import hrb_pkg::*;
    logic clk, sys_rst, fw_result_we, fw_status_pending, fw_ctrl_we, fw_buf_drained;
    logic fw_wr_valid, fw_wr_ready, cs_n, rd_n, wr_n, ack_n, oe_n, irq_n, dma_req;
    logic [15:0] fw_result_wdata, fw_ctrl_wdata, fw_ctrl_word;
    logic [3:0]  addr;
    logic [7:0]  din, dout, q;
    hrb_wr_s     fw_wr;
    int          failures, total_checks, cycles, acc;
    logic [15:0] frame [3] = '{16'h1234, 16'hab01, 16'h80fe};

    hrb_top u_hrb_top (.clk(clk), .sys_rst(sys_rst), .fw_result_we(fw_result_we),
        .fw_result_wdata(fw_result_wdata), .fw_status_pending(fw_status_pending),
        .fw_ctrl_we(fw_ctrl_we), .fw_ctrl_wdata(fw_ctrl_wdata), .fw_ctrl_word(fw_ctrl_word),
        .fw_buf_drained(fw_buf_drained), .fw_wr_valid(fw_wr_valid), .fw_wr(fw_wr),
        .fw_wr_ready(fw_wr_ready), .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n),
        .rx_dma_ack_n(ack_n), .host_address_bits(addr), .host_data_in(din),
        .host_data_out(dout), .host_data_oe_n(oe_n), .host_interrupt_n(irq_n),
        .rx_dma_request(dma_req));
    hrb_host_model u_hrb_host_model (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .ack_n(ack_n), .addr(addr), .din(din), .dout(dout), .oe_n(oe_n));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hrd(input logic [3:0] a, input logic dma, input logic [7:0] e);
        u_hrb_host_model.access(1'b0, dma, a, 8'h00, q);
        chk("host byte", {8'h00, q}, {8'h00, e});
    endtask
    task automatic hwr(input logic [3:0] a, input logic [7:0] d);
        u_hrb_host_model.access(1'b1, 1'b0, a, d, q);
    endtask
    task automatic put(input logic [3:0] i, input logic [15:0] d);
        @(posedge clk);
        fw_wr_valid <= 1'b1;
        fw_wr       <= '{addr: i, data: d};
        @(negedge clk);
        while (!fw_wr_ready) @(negedge clk);
        @(posedge clk);
        fw_wr_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic ctl(input logic [15:0] w);
        @(negedge clk);
        while (!fw_buf_drained) @(negedge clk);
        @(posedge clk);
        fw_ctrl_we    <= 1'b1;
        fw_ctrl_wdata <= w;
        @(posedge clk);
        fw_ctrl_we    <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run;
        end
    end

    initial begin
        {fw_result_we, fw_ctrl_we, fw_wr_valid} = 3'b000;
        {fw_result_wdata, fw_ctrl_wdata} = 32'h0;
        fw_wr   = '{addr: 4'h0, data: 16'h0000};
        sys_rst = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("control word", fw_ctrl_word, 16'h0000);
        chk("interrupt", {15'h0, irq_n}, 16'h0001);
        chk("dma request", {15'h0, dma_req}, 16'h0000);
        $display("test reset done");
        // ------------------------------------------------------------
        // Result word
        // ------------------------------------------------------------
        @(posedge clk);
        fw_result_we    <= 1'b1;
        fw_result_wdata <= 16'hbeef;
        @(posedge clk);
        fw_result_we    <= 1'b0;
        hwr(HRB_A_HW_CTRL, 8'h02);
        hwr(HRB_A_RES_HI, 8'h77);
        chk("pending", {15'h0, fw_status_pending}, 16'h0001);
        chk("interrupt", {15'h0, irq_n}, 16'h0000);
        hrd(HRB_A_RES_LO, 1'b0, 8'hef);
        hrd(HRB_A_RES_HI, 1'b0, 8'hbe);
        chk("pending", {15'h0, fw_status_pending}, 16'h0000);
        chk("interrupt", {15'h0, irq_n}, 16'h0001);
        $display("test result done");
        // ------------------------------------------------------------
        // Frame of three words, processor then DMA
        // ------------------------------------------------------------
        hwr(HRB_A_HW_CTRL, 8'h05);
        for (int i = 0; i < 3; i++) put(4'(i), frame[i]);
        ctl(16'hffe3);
        chk("control word", fw_ctrl_word, 16'h0083);
        chk("dma request", {15'h0, dma_req}, 16'h0001);
        chk("interrupt", {15'h0, irq_n}, 16'h0000);
        hrd(HRB_A_HW_STAT, 1'b0, 8'h0b);
        hrd(HRB_A_RX_LO, 1'b0, frame[0][7:0]);
        hrd(HRB_A_RX_HI, 1'b0, frame[0][15:8]);
        for (int i = 1; i < 3; i++) begin
            hrd(4'h0, 1'b1, frame[i][7:0]);
            hrd(4'h0, 1'b1, frame[i][15:8]);
        end
        // Return, request drop and interrupt release trail the last read
        repeat (2) @(negedge clk);
        chk("control word", fw_ctrl_word, 16'h0003);
        chk("dma request", {15'h0, dma_req}, 16'h0000);
        chk("interrupt", {15'h0, irq_n}, 16'h0001);
        $display("test frame done");
        // ------------------------------------------------------------
        // DMA off, queue stalls while host owns
        // ------------------------------------------------------------
        hwr(HRB_A_HW_CTRL, 8'h01);
        put(4'h0, 16'h5a5a);
        ctl(16'h0081);
        acc = 0;
        @(posedge clk);
        fw_wr_valid <= 1'b1;
        fw_wr       <= '{addr: 4'h1, data: 16'hc3c3};
        repeat (12) begin
            @(negedge clk);
            acc += int'(fw_wr_ready);
            @(posedge clk);
        end
        fw_wr_valid <= 1'b0;
        chk("queued words", 16'(acc), 16'(HRB_FIFO_D));
        chk("dma request", {15'h0, dma_req}, 16'h0000);
        hrd(HRB_A_HW_STAT, 1'b0, 8'h09);
        hrd(HRB_A_RX_LO, 1'b0, 8'h5a);
        hrd(HRB_A_RX_HI, 1'b0, 8'h5a);
        chk("control word", fw_ctrl_word, 16'h0001);
        hrd(4'h0, 1'b1, 8'hc3);
        ctl(16'h0001);
        chk("drained", {15'h0, fw_buf_drained}, 16'h0001);
        $display("test stall done");
        complete_run;
    end
endmodule
